// file: verilog/phr_top.sv
// peak memories, contact decode and print/serial configuration with APB access
`timescale 1ns/100ps
module phr_top
   import phr_pkg::*;
#(
   parameter int MS_DIV = MS_CYCLES
) (
   input wire logic pclk,                          // system clock
   input wire logic presetn,                       // async reset, active low
   input wire logic psel,                          // apb select
   input wire logic penable,                       // apb access phase
   input wire logic pwrite,                        // apb direction
   input wire logic [7:0] paddr,                   // apb byte address
   input wire logic [31:0] pwdata,                 // apb write data
   output logic [31:0] prdata,                     // apb read data
   output logic pready,                            // apb ready
   output logic pslverr,                           // apb error
   input wire logic signed [W_VAL-1:0] gross_value, // gross measured value
   input wire logic signed [W_VAL-1:0] net_value,  // net measured value
   input wire logic signed [W_VAL-1:0] full_scale, // current full scale
   input wire logic sample_valid,                  // new sample strobe
   input wire logic [N_CONTACT-1:0] contact_in,    // contact levels, 1 = 24 V
   input wire logic [N_RMT-1:0] remote_state,      // asserted output states
   input wire logic measuring_mode,                // device in measuring mode
   input wire logic key_tare,                      // tare key pulse
   input wire logic key_zero,                      // zero key pulse
   input wire logic key_print,                     // print key pulse
   output logic signed [W_VAL-1:0] max_memory_value, // maximum memory
   output logic signed [W_VAL-1:0] min_memory_value, // minimum memory
   output logic signed [W_VAL:0] span_memory_value, // peak-to-peak
   output logic [N_RMT-1:0] remote_out,            // remote output levels
   output phr_src_t input_source_select,           // selected test source
   output logic tare_pulse,                        // apply tare
   output logic zero_pulse,                        // capture zero
   output logic nv_save_pulse,                     // store tare/zero to nvm
   output logic print_pulse,                       // start printout
   output logic heading_pulse,                     // printout carries heading
   output phr_items_t print_items,                 // enabled print items
   output phr_ser_t serial_cfg,                    // serial framing
   output logic [3:0] set_number,                  // parameter set 1..8
   output logic keyboard_lock,                     // keys locked
   output logic autocal_on,                        // autocalibration on
   output logic analog_net_sel,                    // analog output shows net
   output logic local_indication                   // keyboard-only operation
);

   ////////////////////////////////////////////////////////////////////////
   logic [31:0] ctrl_r;
   logic [15:0] env_r;
   logic [23:0] contact_r;
   logic [31:0] serial_r;
   logic [31:0] status_w;
   logic [31:0] rd_mux;
   logic rd_err;
   logic wr_en;
   logic [15:0] env_nxt;
   logic [3:0] cmd_r;

   assign wr_en = psel & penable & pready & pwrite;

   // one wait state: every access takes setup plus two access cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
      end
   end

   always_comb begin
      rd_err = 1'b0;
      unique case (paddr)
         OFS_CTRL: rd_mux = ctrl_r;
         OFS_ENV: rd_mux = {16'h0000, env_r};
         OFS_CONTACT: rd_mux = {8'h00, contact_r};
         OFS_SERIAL: rd_mux = serial_r;
         OFS_MAX: rd_mux = {{(32-W_VAL){max_memory_value[W_VAL-1]}}, max_memory_value};
         OFS_MIN: rd_mux = {{(32-W_VAL){min_memory_value[W_VAL-1]}}, min_memory_value};
         OFS_SPAN: rd_mux = {{(31-W_VAL){span_memory_value[W_VAL]}}, span_memory_value};
         OFS_STATUS: rd_mux = status_w;
         OFS_CMD: rd_mux = 32'h0000_0000;
         default: begin
            rd_mux = 32'h0000_0000;
            rd_err = 1'b1;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_mux;
         pslverr <= rd_err;
      end else begin
         pslverr <= 1'b0;
      end
   end

   // out-of-range envelope times clamp into the legal band
   always_comb begin
      env_nxt = pwdata[15:0];
      // compare the whole word so large times are not folded by truncation
      if (pwdata > {16'h0000, ENV_MAX_MS}) begin
         env_nxt = ENV_MAX_MS;
      end else if (env_nxt != 16'h0000 && env_nxt < ENV_MIN_MS) begin
         env_nxt = ENV_MIN_MS;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= CTRL_RST;
         env_r <= ENV_RST;
         contact_r <= CONTACT_RST;
         serial_r <= SER_RST;
      end else if (wr_en) begin
         unique case (paddr)
            OFS_CTRL: ctrl_r <= {24'h00_0000, pwdata[7:0]};
            OFS_ENV: env_r <= env_nxt;
            OFS_CONTACT: contact_r <= pwdata[23:0];
            OFS_SERIAL: begin
               serial_r <= {10'h000, pwdata[21:8], 2'b00, pwdata[5:0]};
               if (pwdata[2:0] > BAUD_MAX) begin
                  serial_r[2:0] <= BAUD_MAX;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmd_r <= 4'h0;
      end else begin
         cmd_r <= (wr_en && paddr == OFS_CMD) ? pwdata[3:0] : 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // contact decode: each contact drives the function it is assigned to
   logic [N_CONTACT-1:0] contact_q;
   logic [N_FUNC-1:0] fn_level;
   logic [N_FUNC-1:0] fn_rise;
   logic [N_FUNC-1:0] hit_lv [N_CONTACT];
   logic [N_FUNC-1:0] hit_rs [N_CONTACT];
   logic remote_en;

   assign remote_en = ctrl_r[CTRL_REMOTE];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         contact_q <= '0;
      end else begin
         contact_q <= contact_in;
      end
   end

   genvar gc;
   generate
      for (gc = 0; gc < N_CONTACT; gc++) begin : g_contact
         logic [N_FUNC-1:0] onehot;
         assign onehot = (N_FUNC)'(1) << contact_r[gc*W_FSEL +: W_FSEL];
         // disabled remote means contacts are ignored completely
         assign hit_lv[gc] = (remote_en && contact_in[gc]) ? onehot : '0;
         assign hit_rs[gc] = (remote_en && contact_in[gc] && !contact_q[gc]) ? onehot : '0;
      end
   endgenerate

   always_comb begin
      fn_level = '0;
      fn_rise = '0;
      for (int c = 0; c < N_CONTACT; c++) begin
         fn_level = fn_level | hit_lv[c];
         fn_rise = fn_rise | hit_rs[c];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         set_number <= 4'h1;
         keyboard_lock <= 1'b0;
         autocal_on <= 1'b1;
         analog_net_sel <= 1'b0;
         local_indication <= 1'b0;
         remote_out <= '0;
         input_source_select <= SRC_MEAS;
         serial_cfg <= '0;
         print_items <= '0;
      end else begin
         set_number <= {1'b0, fn_level[FN_CODE3], fn_level[FN_CODE2],
                        fn_level[FN_CODE1]} + 4'h1;
         keyboard_lock <= fn_level[FN_KEYBOARD_LOCK];
         autocal_on <= ~fn_level[FN_AUTOCAL];
         analog_net_sel <= fn_level[FN_GROSS_NET];
         local_indication <= ~remote_en;
         remote_out <= ctrl_r[CTRL_ACT_OFF] ? ~remote_state : remote_state;
         input_source_select <= phr_src_t'(ctrl_r[CTRL_SRC_LO +: 2]);
         serial_cfg <= {serial_r[SER_BAUD_LO +: 3], serial_r[SER_PAR_LO +: 2],
                        serial_r[SER_STOP2]};
         print_items <= phr_items_t'(serial_r[SER_ITEM_LO +: 6]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // tare, zero, print and the nonvolatile save request
   logic do_tare;
   logic do_zero;
   logic do_print;
   logic [7:0] head_cnt_r;
   logic [7:0] head_n;

   assign do_tare = fn_rise[FN_TARE] | (key_tare & ~fn_level[FN_KEYBOARD_LOCK]) | cmd_r[CMD_TARE];
   assign do_zero = fn_rise[FN_ZERO] | (key_zero & ~fn_level[FN_KEYBOARD_LOCK]) | cmd_r[CMD_ZERO];
   // a held print contact starts one printout, not one per cycle
   assign do_print = measuring_mode & (fn_rise[FN_PRINT] | cmd_r[CMD_PRINT] |
                     (key_print & ~fn_level[FN_KEYBOARD_LOCK]));
   assign head_n = serial_r[SER_HEAD_LO +: 8];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tare_pulse <= 1'b0;
         zero_pulse <= 1'b0;
         nv_save_pulse <= 1'b0;
         print_pulse <= 1'b0;
      end else begin
         tare_pulse <= do_tare;
         zero_pulse <= do_zero;
         nv_save_pulse <= ctrl_r[CTRL_SAVE] & (do_tare | do_zero);
         print_pulse <= do_print;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         head_cnt_r <= 8'h00;
         heading_pulse <= 1'b0;
      end else if (do_print) begin
         heading_pulse <= (head_n != 8'h00) && (head_cnt_r == 8'h00);
         head_cnt_r <= (head_cnt_r + 8'h01 >= head_n) ? 8'h00 : head_cnt_r + 8'h01;
      end else begin
         heading_pulse <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // envelope timing: ms tick, then one discharge step per period
   logic [$clog2(MS_DIV)-1:0] ms_cnt_r;
   logic [15:0] env_cnt_r;
   logic ms_tick;
   logic env_on;
   logic env_step_r;

   assign env_on = env_r >= ENV_MIN_MS;
   assign ms_tick = ms_cnt_r == ($clog2(MS_DIV))'(MS_DIV - 1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_cnt_r <= '0;
      end else begin
         ms_cnt_r <= ms_tick ? '0 : ms_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         env_cnt_r <= 16'h0000;
         env_step_r <= 1'b0;
      end else begin
         env_step_r <= 1'b0;
         if (!env_on) begin
            env_cnt_r <= 16'h0000;
         end else if (ms_tick) begin
            if (env_cnt_r + 16'h0001 >= env_r) begin
               env_cnt_r <= 16'h0000;
               env_step_r <= 1'b1;
            end else begin
               env_cnt_r <= env_cnt_r + 16'h0001;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // peak memories; a step discharges one digit toward the input
   logic signed [W_VAL-1:0] src_gross;
   logic signed [W_VAL-1:0] src_net;
   logic signed [W_VAL-1:0] max_in;
   logic signed [W_VAL-1:0] min_in;
   logic signed [W_VAL-1:0] max_nxt;
   logic signed [W_VAL-1:0] min_nxt;
   logic max_run;
   logic min_run;
   logic pk_en;
   logic env_pend_r;

   always_comb begin
      unique case (input_source_select)
         SRC_CAL: begin
            src_gross = full_scale >>> 1;
            src_net = full_scale >>> 1;
         end
         SRC_ZERO: begin
            src_gross = '0;
            src_net = '0;
         end
         default: begin
            src_gross = gross_value;
            src_net = net_value;
         end
      endcase
   end

   assign max_in = ctrl_r[CTRL_MAX_NET] ? src_net : src_gross;
   assign min_in = ctrl_r[CTRL_MIN_NET] ? src_net : src_gross;
   assign pk_en = ctrl_r[CTRL_ENABLE];
   assign max_run = pk_en & sample_valid & ~fn_level[FN_MAX_HOLD];
   assign min_run = pk_en & sample_valid & ~fn_level[FN_MIN_HOLD];

   // a discharge step waits for the next sample so both memories see it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         env_pend_r <= 1'b0;
      end else if (env_step_r) begin
         env_pend_r <= 1'b1;
      end else if (sample_valid) begin
         env_pend_r <= 1'b0;
      end
   end

   always_comb begin
      max_nxt = max_memory_value;
      min_nxt = min_memory_value;
      if (max_run) begin
         if (fn_level[FN_MAX_MODE] || max_in > max_memory_value) begin
            max_nxt = max_in;
         end else if (env_pend_r && max_memory_value > max_in) begin
            max_nxt = max_memory_value - 1'b1;
         end
      end
      if (min_run) begin
         if (fn_level[FN_MIN_MODE] || min_in < min_memory_value) begin
            min_nxt = min_in;
         end else if (env_pend_r && min_memory_value < min_in) begin
            min_nxt = min_memory_value + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         max_memory_value <= '0;
         min_memory_value <= '0;
      end else if (cmd_r[CMD_CLEAR]) begin
         max_memory_value <= max_in;
         min_memory_value <= min_in;
      end else begin
         max_memory_value <= max_nxt;
         min_memory_value <= min_nxt;
      end
   end

   // span follows the maximum memory's hold, not its own
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         span_memory_value <= '0;
      end else if (!fn_level[FN_MAX_HOLD]) begin
         span_memory_value <= (W_VAL+1)'(max_memory_value) - (W_VAL+1)'(min_memory_value);
      end
   end

   assign status_w = {16'h0000, set_number, 2'b00, local_indication, keyboard_lock,
                      autocal_on, analog_net_sel, fn_level[FN_MIN_HOLD],
                      fn_level[FN_MIN_MODE], fn_level[FN_MAX_HOLD],
                      fn_level[FN_MAX_MODE], env_on, pk_en};

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence tare_edge_s;
      remote_en && contact_in[0] && !contact_q[0] && contact_r[3:0] == FN_TARE;
   endsequence

   max_capture_a: assert property (max_run && !fn_level[FN_MAX_MODE] && !cmd_r[CMD_CLEAR]
      && max_in > max_memory_value |=> max_memory_value == $past(max_in))
      else $error("maximum memory missed a larger value");
   min_capture_a: assert property (min_run && !fn_level[FN_MIN_MODE] && !cmd_r[CMD_CLEAR]
      && min_in < min_memory_value |=> min_memory_value == $past(min_in))
      else $error("minimum memory missed a smaller value");
   span_diff_a: assert property (!fn_level[FN_MAX_HOLD] |=> span_memory_value ==
      $past(max_memory_value) - $past(min_memory_value))
      else $error("span is not max minus min");
   disabled_hold_a: assert property (!pk_en && !cmd_r[CMD_CLEAR] |=>
      $stable(max_memory_value) && $stable(min_memory_value))
      else $error("peak memory changed while disabled");
   tare_edge_a: assert property (tare_edge_s |=> tare_pulse)
      else $error("tare contact edge gave no tare");
   polarity_out_a: assert property (ctrl_r[CTRL_ACT_OFF] ##1 ctrl_r[CTRL_ACT_OFF] |->
      remote_out == ~$past(remote_state))
      else $error("inverted polarity not applied");
   set_code_a: assert property (##1 set_number >= 4'h1 && set_number <= 4'h8)
      else $error("parameter set number out of range");
   local_show_a: assert property (!remote_en |=> local_indication && set_number == 4'h1
      && !keyboard_lock)
      else $error("disabled remote still honoured");
   print_mode_a: assert property (print_pulse |-> $past(measuring_mode))
      else $error("print outside measuring mode");
   nv_save_a: assert property (nv_save_pulse |-> tare_pulse || zero_pulse)
      else $error("save without tare or zero change");
   env_range_a: assert property (env_r == 16'h0000 || (env_r >= ENV_MIN_MS
      && env_r <= ENV_MAX_MS))
      else $error("envelope time outside legal band");

endmodule : phr_top

// file: verilog/phr_pkg.sv
// constants, field layouts and carriers of the peak-hold and remote-contact block
// Overview of operation
// - separate maximum and minimum peak memories
// - span derived arithmetically, tied to maximum memory
// - one common discharge rate for peaks
// - global enable stops all capture
// - per-memory gross or net input select
// - envelope ms, zero off, 100..60000 on
// - polarity setting inverts remote output levels
// - six contacts assignable, reset to none
// - max mode contact: low peak, high track
// - max hold contact freezes max and span
// - min mode and hold contacts likewise, but min hold freezes min only, not span
// - tare applied on contact rising edge
// - zero captured on contact rising edge
// - gross/net, autocal, keyboard_lock level functions
// - print contact triggers serial printout
// - three contacts code set, number plus one
// - remote disable leaves keyboard only, local shown
// - input source: measure, half scale, zero
// - baud 300..9600, parity, stop bits selectable
// - heading every N outputs, zero none
// - print only in measuring mode, no dump
// - nonvolatile save on tare or zero change
package phr_pkg;
   localparam int W_VAL = 24;
   localparam int N_CONTACT = 6;
   localparam int N_FUNC = 14;
   localparam int N_RMT = 4;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_ENV = 8'h04;
   localparam logic [7:0] OFS_CONTACT = 8'h08;
   localparam logic [7:0] OFS_SERIAL = 8'h0C;
   localparam logic [7:0] OFS_MAX = 8'h10;
   localparam logic [7:0] OFS_MIN = 8'h14;
   localparam logic [7:0] OFS_SPAN = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;
   localparam logic [7:0] OFS_CMD = 8'h20;
   // control fields
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_MAX_NET = 1;
   localparam int CTRL_MIN_NET = 2;
   localparam int CTRL_REMOTE = 3;
   localparam int CTRL_ACT_OFF = 4;
   localparam int CTRL_SAVE = 5;
   localparam int CTRL_SRC_LO = 6;
   localparam logic [31:0] CTRL_RST = 32'h0000_0009;
   localparam logic [15:0] ENV_RST = 16'h0000;
   localparam logic [15:0] ENV_MIN_MS = 16'h0064;
   localparam logic [15:0] ENV_MAX_MS = 16'hEA60;
   localparam int W_FSEL = 4;
   localparam logic [23:0] CONTACT_RST = 24'h00_0000;
   // serial fields
   localparam int SER_BAUD_LO = 0;
   localparam int SER_PAR_LO = 3;
   localparam int SER_STOP2 = 5;
   localparam int SER_HEAD_LO = 8;
   localparam int SER_ITEM_LO = 16;
   localparam logic [2:0] BAUD_MAX = 3'h5;
   localparam logic [31:0] SER_RST = 32'h0000_0005;
   // command bits
   localparam int CMD_CLEAR = 0;
   localparam int CMD_TARE = 1;
   localparam int CMD_ZERO = 2;
   localparam int CMD_PRINT = 3;
   // timing: one millisecond at 250 MHz
   localparam int CLK_MHZ = 250;
   localparam int MS_US = 1000;
   localparam int MS_CYCLES = CLK_MHZ * MS_US;

   typedef enum logic [3:0] {
      FN_NONE = 4'b0000, FN_AUTOCAL = 4'b0001, FN_TARE = 4'b0010,
      FN_MAX_MODE = 4'b0011, FN_MAX_HOLD = 4'b0100, FN_MIN_MODE = 4'b0101,
      FN_MIN_HOLD = 4'b0110, FN_ZERO = 4'b0111, FN_PRINT = 4'b1000,
      FN_GROSS_NET = 4'b1001, FN_CODE1 = 4'b1010, FN_CODE2 = 4'b1011,
      FN_CODE3 = 4'b1100, FN_KEYBOARD_LOCK = 4'b1101
   } phr_func_t;

   typedef enum logic [1:0] {
      SRC_MEAS = 2'b00, SRC_CAL = 2'b01, SRC_ZERO = 2'b10
   } phr_src_t;

   typedef enum logic [1:0] {
      PAR_NONE = 2'b00, PAR_EVEN = 2'b01, PAR_ODD = 2'b10
   } phr_par_t;

   typedef struct packed {
      logic [2:0] baud_sel;  // 0..5 = 300,600,1200,2400,4800,9600
      logic [1:0] parity;
      logic two_stop;
   } phr_ser_t;

   typedef struct packed {
      logic gross;
      logic net;
      logic max;
      logic min;
      logic minmax;
      logic lvs;
   } phr_items_t;
endpackage : phr_pkg

// file: tb/phr_contacts.sv
// contact driver standing in for the external switches
`timescale 1ns/100ps
module phr_contacts (
   input wire logic pclk,            // system clock
   input wire logic [5:0] level_req, // wanted levels, 1 = 24 V
   output logic [5:0] contact_in     // levels seen at the block
);
   // switch levels settle one clock after the request
   initial contact_in = 6'h00;
   always_ff @(posedge pclk) begin
      contact_in <= level_req;
   end
endmodule : phr_contacts

// file: tb/test_peak_hold_and_remote_contacts.sv
// self-checking bench of the peak-hold and remote-contact block
`timescale 1ns/100ps
module test_peak_hold_and_remote_contacts;
   import phr_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, sample_valid = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic signed [W_VAL-1:0] gross_value = 0, net_value = 0, full_scale = 0;
   logic [5:0] level_req = 6'h00, contact_in;
   logic [3:0] remote_state = 4'h0, remote_out, set_number;
   logic measuring_mode = 1, key_tare = 0, key_zero = 0, key_print = 0, err, tare_pulse;
   logic keyboard_lock, autocal_on, local_indication;
   logic zero_pulse, nv_save_pulse, print_pulse, heading_pulse;
   logic signed [W_VAL-1:0] max_v, min_v;
   logic signed [W_VAL:0] span_v;
   int num_errors = 0, check_count = 0, i, n, m;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] r; logic e;} row_t;
   row_t rows[5] = '{'{8'h04, 32'h0000_0032, 32'h0000_0064, 0}, '{8'h04, 32'h0001_1170,
      32'h0000_EA60, 0}, '{8'h04, 32'h0000_0000, 32'h0000_0000, 0}, '{8'h0C, 32'h0000_0007,
      32'h0000_0005, 0}, '{8'h24, 32'h0000_0001, 32'h0000_0000, 1}};
   phr_contacts i_sw (.pclk(pclk), .level_req(level_req), .contact_in(contact_in));
   phr_top #(.MS_DIV(10)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .gross_value(gross_value), .net_value(net_value),
      .full_scale(full_scale), .sample_valid(sample_valid), .contact_in(contact_in),
      .remote_state(remote_state), .measuring_mode(measuring_mode), .key_tare(key_tare),
      .key_zero(key_zero), .key_print(key_print), .max_memory_value(max_v),
      .min_memory_value(min_v), .span_memory_value(span_v), .remote_out(remote_out),
      .input_source_select(), .tare_pulse(tare_pulse), .zero_pulse(zero_pulse),
      .nv_save_pulse(nv_save_pulse), .print_pulse(print_pulse),
      .heading_pulse(heading_pulse), .print_items(), .serial_cfg(),
      .set_number(set_number), .keyboard_lock(keyboard_lock), .autocal_on(autocal_on),
      .analog_net_sel(), .local_indication(local_indication));
   initial forever #2 pclk = ~pclk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // bus cycle: hold the request until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      for (k = 0; k < 16; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (k == 16) begin num_errors++; report_and_stop(); end
      rd = prdata; err = pslverr;
      psel <= 0; penable <= 0;
   endtask : apb
   task automatic wt(input int c);
      repeat (c) @(posedge pclk);
      #1;
   endtask : wt
   task automatic samp(input logic signed [W_VAL-1:0] g, input logic signed [W_VAL-1:0] nv);
      @(posedge pclk);
      gross_value <= g; net_value <= nv; sample_valid <= 1;
      @(posedge pclk);
      sample_valid <= 0;
      wt(4);
   endtask : samp
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge pclk);
      chk(set_number, 1);
      chk(autocal_on, 1);
      @(posedge pclk) presetn <= 1;
      apb(0, OFS_CTRL, 0); chk(rd, 32'h0000_0009);
      apb(0, OFS_CONTACT, 0); chk(rd, 0);
      $display("reset test done");
      for (i = 0; i < 5; i++) begin
         apb(1, rows[i].a, rows[i].d); chk(err, rows[i].e);
         apb(0, rows[i].a, 0); chk(rd, rows[i].r);
         chk(err, rows[i].e);
      end
      $display("register rows done");
      apb(1, OFS_CMD, 32'h0000_0001);
      samp(24'h00_0064, 0); samp(24'hFF_FFCE, 0);
      chk(32'(max_v), 32'h0000_0064);
      chk(32'(min_v), 32'hFFFF_FFCE);
      chk(32'(span_v), 32'h0000_0096);
      apb(1, OFS_CTRL, 32'h0000_000B); samp(0, 24'h00_012C);
      chk(32'(max_v), 32'h0000_012C);
      apb(1, OFS_CTRL, 32'h0000_000A); samp(0, 24'h00_01F4);
      chk(32'(max_v), 32'h0000_012C);
      $display("peak test done");
      // contact 0 tare, 1..3 set code, 4 max hold, 5 key lock
      apb(1, OFS_CTRL, 32'h0000_0009); apb(1, OFS_CONTACT, 32'h00D4_CBA2);
      @(posedge pclk) level_req <= 6'b11_1010;
      wt(4);
      chk(set_number, 4'h6);
      chk(keyboard_lock, 1);
      samp(24'h00_01F4, 0); chk(32'(max_v), 32'h0000_012C);
      chk(32'(span_v), 32'h0000_015E);
      n = 0;
      @(posedge pclk) level_req <= 6'b11_1011;
      for (i = 0; i < 8; i++) begin wt(1); n += (tare_pulse === 1'b1); end
      chk(n, 1);
      $display("contact test done");
      @(posedge pclk) remote_state <= 4'b0110;
      wt(3); chk(remote_out, 4'b0110);
      apb(1, OFS_CTRL, 32'h0000_0019); wt(3); chk(remote_out, 4'b1001);
      apb(1, OFS_CTRL, 32'h0000_0001); wt(3); chk(local_indication, 1);
      chk(keyboard_lock, 0);
      $display("polarity and remote test done");
      level_req <= 6'h00; apb(1, OFS_CTRL, 32'h0000_0029);
      apb(1, OFS_SERIAL, 32'h0000_0205);
      n = 0; m = 0;
      @(posedge pclk) key_zero <= 1;
      @(posedge pclk) key_zero <= 0;
      repeat (3) begin
         #1 n += (zero_pulse === 1'b1); m += (nv_save_pulse === 1'b1);
         @(posedge pclk);
      end
      chk(n, 1);
      chk(m, 1);
      n = 0; m = 0;
      repeat (2) begin
         @(posedge pclk) key_print <= 1;
         @(posedge pclk) key_print <= 0;
         #1 n += (print_pulse === 1'b1); m += (heading_pulse === 1'b1);
      end
      chk(n, 2);
      chk(m, 1);
      $display("key and print test done");
      report_and_stop();
   end
   initial begin
      #100000 num_errors++;
      report_and_stop();
   end
endmodule : test_peak_hold_and_remote_contacts
